// ===== design/rtf_query.sv
/*
  Command interpreter for the remote time/date and fault table reads.
  Assumes command words, slave reply bytes and memory writes share sys_clk.
*/
// What this block does
// - command 1C2B reads time, master only
// - time request carries no parameter data
// - time values are packed bcd
// - day of week Sunday 1 to Saturday 7
// - time result packed as four words
// - clockless slaves yield no time values
// - command 1C2C reads fault table, master only
// - selector 1 io table, 2 controller
// - io table 32, controller 16 entries
// - six-word header with clear stamp, counts
// - entries from word 7, 21 words each
// - io entry byte layout, spares zeroed
// - controller entry byte layout, spares zeroed
`timescale 1ns/1ps
`default_nettype none
module rtf_query
  import rtf_pkg::*;
#(
  parameter int FIFO_DEPTH = RTF_FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic master_mode,
  input wire logic slave_attached,
  input wire logic slave_rtc_present,
  input wire logic cmd_valid,
  input wire logic [15:0] cmd_word,
  input wire logic cmd_last,
  output logic cmd_ready,
  output logic req_valid,
  output logic [15:0] req_cmd,
  output logic [15:0] req_sel,
  output logic [15:0] req_start,
  output logic [15:0] req_count,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_byte,
  output logic rsp_ready,
  output logic mem_wr_valid,
  output logic [15:0] mem_wr_type,
  output logic [15:0] mem_wr_addr,
  output logic [15:0] mem_wr_data,
  input wire logic mem_wr_ready,
  output logic busy,
  output logic done,
  output logic [15:0] status_code
);
  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  rtf_state_t state_q;
  rtf_state_t state_d;
  logic [15:0] cb_q [RTF_CB_WORDS];
  logic [3:0] idx_q;
  logic cmd_ready_q, req_valid_q, rsp_ready_q, busy_q, done_q;
  logic [15:0] status_q;
  logic [15:0] chk_code;
  logic is_time_q, is_ctrl_q, hold_v_q, data_bad_q;
  logic [7:0] hold_q;
  logic [10:0] rcnt_q, total_q;
  logic [5:0] ep_q;
  logic [15:0] addr_q, mtype_q;
  logic [7:0] mbyte;
  logic chk_bcd, chk_dow, take, pk_in_ready, pk_out_valid, pk_out_ready;
  logic [15:0] pk_word;
  logic f_in_valid, f_in_ready, f_out_valid, f_out_ready;
  logic [RTF_FIFO_WIDTH-1:0] f_in_data, f_out_data, out_q;
  logic out_valid_q;
  logic [16:0] f_end, f_size;

  assign cmd_ready = cmd_ready_q;
  assign req_valid = req_valid_q;
  assign req_cmd = cb_q[W_CMD];
  assign req_sel = cb_q[W_F_SEL];
  assign req_start = cb_q[W_F_START];
  assign req_count = cb_q[W_F_COUNT];
  assign rsp_ready = rsp_ready_q;
  assign mem_wr_valid = out_valid_q;
  assign mem_wr_type = out_q[47:32];
  assign mem_wr_addr = out_q[31:16];
  assign mem_wr_data = out_q[15:0];
  assign busy = busy_q;
  assign done = done_q;
  assign status_code = status_q;
  assign take = rsp_valid && rsp_ready_q;

  // spare byte positions of a fault entry, 1-based
  function automatic logic entry_spare(input logic ctrl, input logic [5:0] p);
    if (ctrl)
      entry_spare = (p <= RTF_CTRL_SPARE_A_HI) || (p == RTF_CTRL_SPARE_B) ||
                    ((p >= RTF_CTRL_SPARE_LO) && (p <= RTF_SPARE_HI));
    else
      entry_spare = (p == RTF_IO_SPARE_A) || ((p >= RTF_IO_SPARE_LO) && (p <= RTF_SPARE_HI));
  endfunction

  // ---------------------------------------------------------------
  // command block capture
  // ---------------------------------------------------------------
  // words land at their fixed positions; extra words are dropped
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < RTF_CB_WORDS; i++)
        cb_q[i] <= 16'h0000;
      idx_q <= 4'h0;
    end
    else if (cmd_valid && cmd_ready_q)
    begin
      if (idx_q < 4'(RTF_CB_WORDS))
        cb_q[idx_q] <= cmd_word;
      idx_q <= cmd_last ? 4'h0 : ((idx_q < 4'(RTF_CB_WORDS)) ? idx_q + 4'h1 : idx_q);
    end
  end

  // ---------------------------------------------------------------
  // request checks
  // ---------------------------------------------------------------
  assign f_size = (cb_q[W_F_SEL] == RTF_SEL_IO) ? RTF_IO_SIZE : RTF_CTRL_SIZE;
  assign f_end = {1'b0, cb_q[W_F_START]} + {1'b0, cb_q[W_F_COUNT]};

  // first failing check decides the status word
  always_comb
  begin
    chk_code = RTF_ST_OK;
    if (!master_mode)
      chk_code = RTF_ST_MODE;
    else if (cb_q[W_CMD] != RTF_CMD_TIME && cb_q[W_CMD] != RTF_CMD_FAULT)
      chk_code = RTF_ST_CMD;
    else if (!slave_attached)
      chk_code = RTF_ST_ATTACH;
    else if (cb_q[W_LEN] != ((cb_q[W_CMD] == RTF_CMD_TIME) ? RTF_LEN_TIME : RTF_LEN_FAULT))
      chk_code = RTF_ST_LEN;
    else if (cb_q[W_CMD] == RTF_CMD_FAULT &&
             cb_q[W_F_SEL] != RTF_SEL_IO && cb_q[W_F_SEL] != RTF_SEL_CTRL)
      chk_code = RTF_ST_SEL;
    else if (cb_q[W_CMD] == RTF_CMD_FAULT && (cb_q[W_F_START] == 16'h0000 ||
             cb_q[W_F_COUNT] == 16'h0000 || f_end > f_size + 17'h00001))
      chk_code = RTF_ST_RANGE;
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  // load, check, ask the slave, take the reply, post status
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_LOAD: if (cmd_valid && cmd_ready_q && cmd_last) state_d = ST_CHECK;
      ST_CHECK: state_d = (chk_code == RTF_ST_OK) ? ST_REQ : ST_STAT;
      ST_REQ: if (req_ready) state_d = ST_RECV;
      ST_RECV: if (rcnt_q == total_q && !hold_v_q && !pk_out_valid) state_d = ST_STAT;
      ST_STAT: if (f_in_ready) state_d = ST_DONE;
      ST_DONE: if (!f_out_valid && !out_valid_q) state_d = ST_LOAD;
      default: state_d = ST_LOAD;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      state_q <= ST_LOAD;
    else
      state_q <= state_d;
  end

  // handshake and progress flags
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cmd_ready_q <= 1'b0;
      req_valid_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      cmd_ready_q <= (state_d == ST_LOAD) && !(cmd_valid && cmd_ready_q && cmd_last);
      req_valid_q <= (state_d == ST_REQ);
      busy_q <= (state_d != ST_LOAD);
      done_q <= (state_q == ST_DONE) && (state_d == ST_LOAD);
    end
  end

  // result kind, sizes, destination and status
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      is_time_q <= 1'b0;
      is_ctrl_q <= 1'b0;
      total_q <= 11'h000;
      mtype_q <= 16'h0000;
      status_q <= 16'h0000;
    end
    else if (state_q == ST_CHECK)
    begin
      is_time_q <= (cb_q[W_CMD] == RTF_CMD_TIME);
      is_ctrl_q <= (cb_q[W_F_SEL] == RTF_SEL_CTRL);
      status_q <= chk_code;
      if (cb_q[W_CMD] == RTF_CMD_TIME)
      begin
        total_q <= RTF_TIME_BYTES;
        mtype_q <= cb_q[W_T_MTYPE];
      end
      else
      begin
        total_q <= 11'(RTF_HDR_BYTES + RTF_ENTRY_BYTES * 11'(cb_q[W_F_COUNT][5:0]));
        mtype_q <= cb_q[W_F_MTYPE];
      end
    end
    else if (state_q == ST_RECV && state_d == ST_STAT && data_bad_q)
      status_q <= RTF_ST_DATA;
  end

  // ---------------------------------------------------------------
  // reply byte handling
  // ---------------------------------------------------------------
  // zero spares and absent values, pick bytes that must be bcd
  always_comb
  begin
    mbyte = rsp_byte;
    chk_bcd = 1'b0;
    chk_dow = 1'b0;
    if (is_time_q)
    begin
      if (rcnt_q == RTF_TIME_PAD_IDX)
        mbyte = 8'h00;
      else if (!slave_rtc_present)
        mbyte = 8'h00;
      else if (rcnt_q == RTF_TIME_DOW_IDX)
        chk_dow = 1'b1;
      else
        chk_bcd = 1'b1;
    end
    else if (rcnt_q < RTF_HDR_BYTES)
      chk_bcd = (rcnt_q < RTF_HDR_STAMP_BYTES);
    else if (entry_spare(is_ctrl_q, ep_q))
      mbyte = 8'h00;
    else
      chk_bcd = (ep_q >= RTF_STAMP_POS);
  end

  // one byte held at a time; ready drops while it waits
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rsp_ready_q <= 1'b0;
      hold_v_q <= 1'b0;
      hold_q <= 8'h00;
      rcnt_q <= 11'h000;
      ep_q <= RTF_ENTRY_FIRST;
      data_bad_q <= 1'b0;
    end
    else if (state_q == ST_CHECK)
    begin
      rcnt_q <= 11'h000;
      ep_q <= RTF_ENTRY_FIRST;
      data_bad_q <= 1'b0;
      hold_v_q <= 1'b0;
      rsp_ready_q <= 1'b0;
    end
    else
    begin
      rsp_ready_q <= (state_q == ST_RECV) && !take && !hold_v_q && (rcnt_q < total_q);
      if (hold_v_q && pk_in_ready)
        hold_v_q <= 1'b0;
      if (take)
      begin
        hold_v_q <= 1'b1;
        hold_q <= mbyte;
        rcnt_q <= rcnt_q + 11'h001;
        if (!is_time_q && rcnt_q >= RTF_HDR_BYTES)
          ep_q <= (ep_q == RTF_ENTRY_LAST) ? RTF_ENTRY_FIRST : ep_q + 6'h01;
        if ((chk_bcd && !rtf_bcd_ok(rsp_byte)) ||
            (chk_dow && (rsp_byte < RTF_DOW_MIN || rsp_byte > RTF_DOW_MAX)))
          data_bad_q <= 1'b1;
      end
    end
  end

  rtf_byte_packer u_packer (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .clr(state_q == ST_CHECK),
    .in_valid(hold_v_q),
    .in_byte(hold_q),
    .in_ready(pk_in_ready),
    .out_valid(pk_out_valid),
    .out_word(pk_word),
    .out_ready(pk_out_ready)
  );

  // ---------------------------------------------------------------
  // memory write path
  // ---------------------------------------------------------------
  // result words go to consecutive addresses, then the status word
  assign pk_out_ready = f_in_ready && (state_q == ST_RECV);
  assign f_in_valid = (state_q == ST_RECV) ? pk_out_valid : (state_q == ST_STAT);
  assign f_in_data = (state_q == ST_STAT) ?
                     {cb_q[W_STYPE], cb_q[W_SADDR] + 16'h0001, status_q} : {mtype_q, addr_q, pk_word};

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      addr_q <= 16'h0000;
    else if (state_q == ST_CHECK)
      addr_q <= is_time_q ? cb_q[W_T_MADDR] : cb_q[W_F_MADDR];
    else if (state_q == ST_REQ)
      addr_q <= is_time_q ? cb_q[W_T_MADDR] : cb_q[W_F_MADDR];
    else if (pk_out_valid && pk_out_ready)
      addr_q <= addr_q + 16'h0001;
  end

  rtf_fifo #(
    .WIDTH(RTF_FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .in_valid(f_in_valid),
    .in_data(f_in_data),
    .in_ready(f_in_ready),
    .out_valid(f_out_valid),
    .out_data(f_out_data),
    .out_ready(f_out_ready)
  );

  // output stage keeps the write port on flip-flops
  assign f_out_ready = !out_valid_q || mem_wr_ready;
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      out_valid_q <= 1'b0;
      out_q <= '0;
    end
    else if (f_out_ready)
    begin
      out_valid_q <= f_out_valid;
      if (f_out_valid)
        out_q <= f_out_data;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_master_only;
    @(posedge sys_clk) disable iff (!rst_b)
    (state_q == ST_CHECK && !master_mode) |=> (state_q == ST_STAT && status_q == RTF_ST_MODE);
  endproperty
  a_master_only: assert property (p_master_only) else $error("request taken outside master mode");

  property p_attach;
    @(posedge sys_clk) disable iff (!rst_b)
    (state_q == ST_CHECK && master_mode && !slave_attached) |=> (state_q == ST_STAT);
  endproperty
  a_attach: assert property (p_attach) else $error("request sent without attach");

  property p_req_hold;
    @(posedge sys_clk) disable iff (!rst_b)
    (req_valid_q && !req_ready) |=> req_valid_q && $stable(req_cmd);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped before taken");

  property p_pad_zero;
    @(posedge sys_clk) disable iff (!rst_b)
    (take && is_time_q && rcnt_q == RTF_TIME_PAD_IDX) |=> (hold_q == 8'h00);
  endproperty
  a_pad_zero: assert property (p_pad_zero) else $error("unused time byte not zero");

  property p_no_rtc;
    @(posedge sys_clk) disable iff (!rst_b)
    (take && is_time_q && !slave_rtc_present) |=> (hold_q == 8'h00);
  endproperty
  a_no_rtc: assert property (p_no_rtc) else $error("clockless slave value passed");

  property p_sel_reject;
    @(posedge sys_clk) disable iff (!rst_b)
    (state_q == ST_CHECK && chk_code == RTF_ST_SEL) |=> (state_q == ST_STAT && status_q == RTF_ST_SEL) ##[1:8] (state_q == ST_DONE);
  endproperty
  a_sel_reject: assert property (p_sel_reject) else $error("bad selector not reported");

  property p_fault_total;
    @(posedge sys_clk) disable iff (!rst_b)
    (state_q == ST_REQ && !is_time_q) |-> (total_q == 11'(RTF_HDR_BYTES + RTF_ENTRY_BYTES * 11'(req_count[5:0])));
  endproperty
  a_fault_total: assert property (p_fault_total) else $error("fault result size wrong");

  property p_spare_zero;
    @(posedge sys_clk) disable iff (!rst_b)
    (take && !is_time_q && rcnt_q >= RTF_HDR_BYTES && entry_spare(is_ctrl_q, ep_q)) |=> (hold_q == 8'h00);
  endproperty
  a_spare_zero: assert property (p_spare_zero) else $error("spare entry byte not zero");

  property p_ctrl_spare;
    @(posedge sys_clk) disable iff (!rst_b)
    (take && is_ctrl_q && !is_time_q && ep_q == RTF_CTRL_SPARE_B) |=> (hold_q == 8'h00);
  endproperty
  a_ctrl_spare: assert property (p_ctrl_spare) else $error("controller spare byte not zero");
endmodule // rtf_query
`default_nettype wire

// ===== design/rtf_pkg.sv
/*
  Constants, state encoding and shared helpers for the remote time/fault
  query interpreter. Assumes 16-bit command block words and byte replies.
*/
package rtf_pkg;
  // ---------------------------------------------------------------
  // command numbers and command block word indices (0-based)
  // ---------------------------------------------------------------
  localparam logic [15:0] RTF_CMD_TIME = 16'h1c2b;
  localparam logic [15:0] RTF_CMD_FAULT = 16'h1c2c;
  localparam int RTF_CB_WORDS = 12;
  localparam int W_LEN = 0;
  localparam int W_WAIT = 1;
  localparam int W_STYPE = 2;
  localparam int W_SADDR = 3;
  localparam int W_CMD = 6;
  localparam int W_T_MTYPE = 7;
  localparam int W_T_MADDR = 8;
  localparam int W_F_SEL = 7;
  localparam int W_F_START = 8;
  localparam int W_F_COUNT = 9;
  localparam int W_F_MTYPE = 10;
  localparam int W_F_MADDR = 11;
  localparam logic [15:0] RTF_LEN_TIME = 16'h0003;
  localparam logic [15:0] RTF_LEN_FAULT = 16'h0006;
  // ---------------------------------------------------------------
  // table selection, sizes and result layout
  // ---------------------------------------------------------------
  localparam logic [15:0] RTF_SEL_IO = 16'h0001;
  localparam logic [15:0] RTF_SEL_CTRL = 16'h0002;
  localparam logic [16:0] RTF_IO_SIZE = 17'h00020;
  localparam logic [16:0] RTF_CTRL_SIZE = 17'h00010;
  localparam logic [10:0] RTF_TIME_BYTES = 11'h008;
  localparam logic [10:0] RTF_TIME_DOW_IDX = 11'h006;
  localparam logic [10:0] RTF_TIME_PAD_IDX = 11'h007;
  localparam logic [10:0] RTF_HDR_BYTES = 11'h00c;
  localparam logic [10:0] RTF_HDR_STAMP_BYTES = 11'h006;
  localparam logic [10:0] RTF_ENTRY_BYTES = 11'h02a;
  localparam logic [5:0] RTF_ENTRY_LAST = 6'h2a;
  localparam logic [5:0] RTF_ENTRY_FIRST = 6'h01;
  localparam logic [5:0] RTF_STAMP_POS = 6'h25;
  localparam logic [5:0] RTF_IO_SPARE_A = 6'h01;
  localparam logic [5:0] RTF_IO_SPARE_LO = 6'h10;
  localparam logic [5:0] RTF_CTRL_SPARE_A_HI = 6'h04;
  localparam logic [5:0] RTF_CTRL_SPARE_B = 6'h08;
  localparam logic [5:0] RTF_CTRL_SPARE_LO = 6'h0d;
  localparam logic [5:0] RTF_SPARE_HI = 6'h24;
  localparam logic [7:0] RTF_DOW_MIN = 8'h01;
  localparam logic [7:0] RTF_DOW_MAX = 8'h07;
  // ---------------------------------------------------------------
  // status word codes and buffering
  // ---------------------------------------------------------------
  localparam logic [15:0] RTF_ST_OK = 16'h0001;
  localparam logic [15:0] RTF_ST_MODE = 16'h0102;
  localparam logic [15:0] RTF_ST_CMD = 16'h0202;
  localparam logic [15:0] RTF_ST_ATTACH = 16'h0302;
  localparam logic [15:0] RTF_ST_LEN = 16'h0402;
  localparam logic [15:0] RTF_ST_SEL = 16'h0502;
  localparam logic [15:0] RTF_ST_RANGE = 16'h0602;
  localparam logic [15:0] RTF_ST_DATA = 16'h0702;
  localparam int RTF_FIFO_DEPTH = 8;
  localparam int RTF_FIFO_WIDTH = 48;

  typedef enum logic [5:0] {
    ST_LOAD = 6'h01,
    ST_CHECK = 6'h02,
    ST_REQ = 6'h04,
    ST_RECV = 6'h08,
    ST_STAT = 6'h10,
    ST_DONE = 6'h20
  } rtf_state_t;

  // both nibbles of a packed bcd byte in 0..9
  function automatic logic rtf_bcd_ok(input logic [7:0] b);
    rtf_bcd_ok = (b[7:4] <= 4'h9) && (b[3:0] <= 4'h9);
  endfunction
endpackage

// ===== design/rtf_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes one clock; width and depth set by parameters, depth a power of two.
*/
`timescale 1ns/1ps
`default_nettype none
module rtf_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  // honest full and empty from the fill count
  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // storage write
  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem_q[wr_q] <= in_data;
  end

  // pointers and count
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
        rd_q <= rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // rtf_fifo
`default_nettype wire

// ===== design/rtf_byte_packer.sv
/*
  Packs a byte stream into 16-bit words, first byte in the low half.
  Assumes clr is raised before each new result stream.
*/
`timescale 1ns/1ps
`default_nettype none
module rtf_byte_packer (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clr,
  input wire logic in_valid,
  input wire logic [7:0] in_byte,
  output logic in_ready,
  output logic out_valid,
  output logic [15:0] out_word,
  input wire logic out_ready
);
  logic have_lo_q;
  logic [7:0] lo_q;
  logic out_valid_q;
  logic [15:0] word_q;

  assign in_ready = !out_valid_q;
  assign out_valid = out_valid_q;
  assign out_word = word_q;

  // low byte held, high byte completes the word
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      have_lo_q <= 1'b0;
      lo_q <= 8'h00;
      out_valid_q <= 1'b0;
      word_q <= 16'h0000;
    end
    else if (clr)
    begin
      have_lo_q <= 1'b0;
      out_valid_q <= 1'b0;
    end
    else
    begin
      if (out_valid_q && out_ready)
        out_valid_q <= 1'b0;
      if (in_valid && in_ready)
      begin
        if (!have_lo_q)
        begin
          lo_q <= in_byte;
          have_lo_q <= 1'b1;
        end
        else
        begin
          word_q <= {in_byte, lo_q};
          out_valid_q <= 1'b1;
          have_lo_q <= 1'b0;
        end
      end
    end
  end
endmodule // rtf_byte_packer
`default_nettype wire

// ===== verif/rtf_slave_model.sv
/*
  Behavioural remote slave: answers each request with a bcd byte stream, first byte non-bcd when slow.
  Assumes requests and replies share sys_clk with the interpreter.
*/
`timescale 1ns/1ps
`default_nettype none
module rtf_slave_model (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic slow,
  input wire logic req_valid,
  input wire logic [15:0] req_cmd,
  input wire logic [15:0] req_count,
  output logic req_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_byte,
  input wire logic rsp_ready
);
  int n;
  // take one request, then stream bytes counting up in bcd
  initial
  begin
    req_ready = 1'b0;
    rsp_valid = 1'b0;
    rsp_byte = 8'h5a;
    forever
    begin
      @(posedge sys_clk);
      if (rst_b && req_valid)
      begin
        repeat (slow ? 3 : 0) @(posedge sys_clk);
        req_ready <= 1'b1;
        @(posedge sys_clk);
        req_ready <= 1'b0;
        n = (req_cmd == 16'h1c2b) ? 8 : 12 + 42 * int'(req_count); // length from command and count
        for (int k = 1; k <= n; k++)
        begin
          rsp_valid <= 1'b1;
          rsp_byte <= (slow && k == 1) ? 8'h1a : {4'((k % 100) / 10), 4'(k % 10)}; // bcd, slow opens bad
          do @(posedge sys_clk); while (!rsp_ready);
          if (slow)
          begin
            rsp_valid <= 1'b0;
            rsp_byte <= ~rsp_byte;
            repeat (2) @(posedge sys_clk);
          end
        end
        rsp_valid <= 1'b0;
        rsp_byte <= ~rsp_byte;
      end
    end
  end
endmodule // rtf_slave_model
`default_nettype wire

// ===== verif/testbench.sv
/*
  Self-checking bench: command blocks in, memory writes checked from a queue.
  Assumes the slave model on the reply side and one 20 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rtf_pkg::*;
  logic sys_clk, rst_b, master_mode, slave_attached, slave_rtc_present, slow_q;
  logic cmd_valid, cmd_last, cmd_ready, req_valid, req_ready, rsp_valid, rsp_ready;
  logic mem_wr_valid, mem_wr_ready, busy, done;
  logic [15:0] cmd_word, req_cmd, req_sel, req_start, req_count, mem_wr_type, mem_wr_addr, mem_wr_data, status_code;
  logic [7:0] rsp_byte;
  logic [31:0] lfsr_q;
  logic [47:0] exp_q[$];
  int errors, total_checks, cycles;
  rtf_query i_rtf_query (.sys_clk(sys_clk), .rst_b(rst_b), .master_mode(master_mode),
    .slave_attached(slave_attached), .slave_rtc_present(slave_rtc_present), .cmd_valid(cmd_valid),
    .cmd_word(cmd_word), .cmd_last(cmd_last), .cmd_ready(cmd_ready), .req_valid(req_valid),
    .req_cmd(req_cmd), .req_sel(req_sel), .req_start(req_start), .req_count(req_count),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_byte(rsp_byte), .rsp_ready(rsp_ready),
    .mem_wr_valid(mem_wr_valid), .mem_wr_type(mem_wr_type), .mem_wr_addr(mem_wr_addr),
    .mem_wr_data(mem_wr_data), .mem_wr_ready(mem_wr_ready), .busy(busy), .done(done),
    .status_code(status_code));
  rtf_slave_model i_rtf_slave_model (.sys_clk(sys_clk), .rst_b(rst_b), .slow(slow_q),
    .req_valid(req_valid), .req_cmd(req_cmd), .req_count(req_count), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_byte(rsp_byte), .rsp_ready(rsp_ready));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // one command block: note expected writes, send words, wait for done
  task automatic run(input logic m, a, r, s, input logic [15:0] len, cmd, sel, st, cnt, es);
    logic [15:0] w [12];
    logic [15:0] sa, da;
    logic [7:0] b, lo;
    logic t;
    int nb, p, k;
    begin
      t = (cmd == RTF_CMD_TIME);
      sa = {8'h00, lfsr_q[7:0]};
      da = {4'h1, lfsr_q[19:8]}; // room for every result word
      w = '{len, 16'h0, 16'h0008, sa, 16'h0, 16'h0, cmd, t ? 16'h0008 : sel, t ? da : st, t ? 16'h0 : cnt,
        t ? 16'h0 : 16'h0008, t ? 16'h0 : da}; // time or fault word order
      nb = (es != RTF_ST_OK && es != RTF_ST_DATA) ? 0 : t ? 8 : 12 + 42 * int'(cnt);
      for (int i = 0; i < nb; i++)
      begin
        b = {4'(((i + 1) % 100) / 10), 4'((i + 1) % 10)};
        p = (i - 12) % 42 + 1;
        if (s && i == 0)
          b = 8'h1a; // slow slave opens with a non-bcd byte
        if (t && (!r || i == 7))
          b = 8'h00; // clockless slave and pad byte give zero
        else if (i >= 12 && (sel == RTF_SEL_IO ? (p == 1 || (p >= 16 && p <= 36)) : (p <= 4 || p == 8 || (p >= 13 && p <= 36))))
          b = 8'h00; // spare entry bytes
        if (i % 2 == 0)
          lo = b;
        else
          exp_q.push_back({16'h0008, da + 16'(i / 2), b, lo});
      end
      exp_q.push_back({16'h0008, sa + 16'h1, es});
      @(posedge sys_clk);
      master_mode <= m;
      slave_attached <= a;
      slave_rtc_present <= r;
      slow_q <= s;
      for (int i = 0; i < ((cmd == RTF_CMD_TIME) ? 9 : 12); i++)
      begin
        cmd_valid <= 1'b1;
        cmd_word <= w[i];
        cmd_last <= (i == ((cmd == RTF_CMD_TIME) ? 8 : 11));
        do @(posedge sys_clk); while (cmd_ready !== 1'b1);
      end
      cmd_valid <= 1'b0;
      k = 0;
      do
      begin
        @(posedge sys_clk);
        k++;
      end
      while (done !== 1'b1 && k < 20000);
      check({32'h0, status_code}, {32'h0, es}); // status of the block
      check({46'h0, done, busy}, 48'h2); // finished in time, idle again
      if (!t)
        check({req_sel, req_start, req_count}, {sel, st, cnt}); // fault parameters to the slave
      check(48'(exp_q.size()), 48'h0); // every result word written
    end
  endtask
  // ---------------------------------------------------------------
  // clock, reset, memory back-pressure, write monitor
  // ---------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // random stall of memory writes, heavy while slow_q is clear
  always @(posedge sys_clk)
  begin
    lfsr_q <= lfsr_next(lfsr_q);
    mem_wr_ready <= slow_q ? (lfsr_q[0] | lfsr_q[3]) : (lfsr_q[2:0] == 3'h0);
    cycles++;
    if (cycles == 100000)
    begin
      errors++;
      final_report();
    end
  end
  // each accepted write must match the oldest note
  always @(posedge sys_clk)
    if (rst_b && mem_wr_valid === 1'b1 && mem_wr_ready)
      check({mem_wr_type, mem_wr_addr, mem_wr_data}, exp_q.size() ? exp_q.pop_front() : 48'hx); // layout
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    {rst_b, master_mode, slave_attached, slave_rtc_present, slow_q, cmd_valid, cmd_last, mem_wr_ready} = '0;
    cmd_word = 16'h0;
    lfsr_q = 32'h5720191f;
    errors = 0;
    total_checks = 0;
    cycles = 0;
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    run(1, 1, 1, 0, 3, RTF_CMD_TIME, 0, 0, 0, RTF_ST_OK); // saturday 07 kept
    run(1, 1, 0, 1, 3, RTF_CMD_TIME, 0, 0, 0, RTF_ST_OK); // no clock
    run(1, 1, 1, 1, 6, RTF_CMD_FAULT, 1, 32, 1, RTF_ST_DATA); // last io entry, bad bcd
    run(1, 1, 1, 0, 6, RTF_CMD_FAULT, 2, 15, 2, RTF_ST_OK); // controller table end
    run(1, 1, 1, 0, 6, RTF_CMD_FAULT, 1, 1, 32, RTF_ST_OK); // whole io table
    run(1, 1, 1, 0, 6, RTF_CMD_FAULT, 2, 16, 2, RTF_ST_RANGE); // past table end
    run(1, 1, 1, 0, 6, RTF_CMD_FAULT, 3, 1, 1, RTF_ST_SEL); // bad selector
    run(0, 1, 1, 0, 3, RTF_CMD_TIME, 0, 0, 0, RTF_ST_MODE); // not master
    run(1, 0, 1, 0, 6, RTF_CMD_FAULT, 1, 1, 1, RTF_ST_ATTACH); // not attached
    run(1, 1, 1, 0, 6, RTF_CMD_TIME, 0, 0, 0, RTF_ST_LEN); // wrong length
    run(1, 1, 1, 0, 6, 16'h1c2d, 1, 1, 1, RTF_ST_CMD); // other command
    final_report();
  end
endmodule // testbench
`default_nettype wire
